// >>> core/swdbg_pkg.sv
package swdbg_pkg;

    // Bit timing, timeout, steal and stall delays, all in bus-clock cycles
    localparam int unsigned BIT_CYCLES   = 16;
    localparam int unsigned SAMPLE_AT    = 10;
    localparam int unsigned SPEEDUP_AT   = 7;
    localparam int unsigned ZERO_LOW     = 13;
    localparam int unsigned SPEEDUP_LEN  = 1;
    localparam int unsigned TIMEOUT_CYC  = 512;
    localparam int unsigned STEAL_AFTER  = 128;
    localparam int unsigned IGNORE_DLY   = 4;

    localparam logic [4:0] CNT_SAMPLE  = 5'(SAMPLE_AT);
    localparam logic [4:0] CNT_ONE_HI  = 5'(SPEEDUP_AT - 1);
    localparam logic [4:0] CNT_ONE_REL = 5'(SPEEDUP_AT + SPEEDUP_LEN - 1);
    localparam logic [4:0] CNT_ZERO_HI = 5'(ZERO_LOW - 1);
    localparam logic [4:0] CNT_ZERO_RL = 5'(ZERO_LOW + SPEEDUP_LEN - 1);
    localparam logic [4:0] CNT_LAST    = 5'(BIT_CYCLES - 1);
    localparam logic [9:0] IDLE_LAST   = 10'(TIMEOUT_CYC - 1);
    localparam logic [7:0] STEAL_LAST  = 8'(STEAL_AFTER - 1);
    localparam logic [2:0] IGN_LAST    = 3'(IGNORE_DLY - 1);

    // Command opcodes
    localparam logic [7:0] OP_BACKGROUND = 8'h90;
    localparam logic [7:0] OP_DBG_RD_B   = 8'hE4;
    localparam logic [7:0] OP_DBG_RD_W   = 8'hEC;
    localparam logic [7:0] OP_RD_B       = 8'hE0;
    localparam logic [7:0] OP_RD_W       = 8'hE8;
    localparam logic [7:0] OP_DBG_WR_B   = 8'hC4;
    localparam logic [7:0] OP_DBG_WR_W   = 8'hCC;
    localparam logic [7:0] OP_WR_B       = 8'hC0;
    localparam logic [7:0] OP_WR_W       = 8'hC8;

    // Debug map and status byte
    localparam logic [15:0] STATUS_ADDR  = 16'hFF01;
    localparam logic [15:0] DBG_REG_TOP  = 16'hFF06;
    localparam logic [15:0] DBG_MAP_BASE = 16'hFF00;
    localparam int unsigned ENA_BIT      = 7;
    localparam int unsigned ACT_BIT      = 6;
    localparam logic [7:0]  STATUS_RST   = 8'h00;

    localparam logic [3:0] BITS_OP   = 4'h7;
    localparam logic [3:0] BITS_WORD = 4'hF;

    typedef enum logic [5:0] {
        ST_OPCODE = 6'b000001,
        ST_ADDR   = 6'b000010,
        ST_WDATA  = 6'b000100,
        ST_WAIT   = 6'b001000,
        ST_ACCESS = 6'b010000,
        ST_RDATA  = 6'b100000
    } swdbg_state_t;

endpackage : swdbg_pkg

// >>> core/swdbg_bitio.sv
`timescale 1ns/1ps
`default_nettype none

module swdbg_bitio (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_in,
    input  wire logic tx_en,
    input  wire logic tx_bit,
    output var  logic pin_out,
    output var  logic pin_oe,
    output var  logic rx_valid,
    output var  logic rx_bit,
    output var  logic timeout
);

    logic       sync1_q;
    logic       sync2_q;
    logic       sync3_q;
    logic       busy_q;
    logic [4:0] cnt_q;
    logic       txm_q;
    logic       txb_q;
    logic [9:0] idle_q;
    logic       idle_sat_q;
    logic       fall;

    // First stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign fall = sync3_q & ~sync2_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 5'h00;
            txm_q  <= 1'b0;
            txb_q  <= 1'b0;
        end else if (fall) begin
            busy_q <= 1'b1;
            cnt_q  <= 5'h00;
            txm_q  <= tx_en;
            txb_q  <= tx_bit;
        end else if (busy_q) begin
            cnt_q  <= cnt_q + 5'h01;
            busy_q <= (cnt_q != swdbg_pkg::CNT_LAST);
        end
    end

    // Pin drive: low for a zero, brief high speed-up in both cases
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_oe  <= 1'b0;
            pin_out <= 1'b1;
        end else if (fall) begin
            pin_oe  <= tx_en & ~tx_bit;
            pin_out <= 1'b0;
        end else if (busy_q && txm_q && !txb_q) begin
            if (cnt_q == swdbg_pkg::CNT_ZERO_HI) begin
                pin_out <= 1'b1;
            end else if (cnt_q == swdbg_pkg::CNT_ZERO_RL) begin
                pin_oe  <= 1'b0;
            end
        end else if (busy_q && txm_q && txb_q) begin
            if (cnt_q == swdbg_pkg::CNT_ONE_HI) begin
                pin_oe  <= 1'b1;
                pin_out <= 1'b1;
            end else if (cnt_q == swdbg_pkg::CNT_ONE_REL) begin
                pin_oe  <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_valid <= 1'b0;
            rx_bit   <= 1'b0;
        end else begin
            rx_valid <= busy_q && !fall && (cnt_q == swdbg_pkg::CNT_SAMPLE);
            if (busy_q && !fall && cnt_q == swdbg_pkg::CNT_SAMPLE) begin
                rx_bit <= sync2_q;
            end
        end
    end

    // Saturate so one silence gives one timeout pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_q     <= 10'h000;
            idle_sat_q <= 1'b0;
            timeout    <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (fall) begin
                idle_q     <= 10'h000;
                idle_sat_q <= 1'b0;
            end else if (!idle_sat_q) begin
                idle_q <= idle_q + 10'h001;
                if (idle_q == swdbg_pkg::IDLE_LAST) begin
                    idle_sat_q <= 1'b1;
                    timeout    <= 1'b1;
                end
            end
        end
    end

endmodule : swdbg_bitio

`default_nettype wire

// >>> core/swdbg_core.sv
`timescale 1ns/1ps
`default_nettype none

module swdbg_core (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        debug_wire_pin_in,
    output var  logic        debug_wire_pin_out,
    output var  logic        debug_wire_pin_oe,
    input  wire logic        special_single_chip,
    input  wire logic        instr_boundary,
    input  wire logic        tag_hit,
    input  wire logic        halt_to_debug_instruction,
    input  wire logic        firmware_exit,
    input  wire logic        bus_idle,
    input  wire logic        acc_done,
    input  wire logic [15:0] acc_rdata,
    output var  logic        acc_req_q,
    output var  logic [15:0] acc_addr_q,
    output var  logic        acc_write_q,
    output var  logic [1:0]  acc_lane_q,
    output var  logic [15:0] acc_wdata_q,
    output var  logic        acc_debug_map_q,
    output var  logic        cpu_freeze_q,
    output var  logic        cpu_stall_q,
    output var  logic        debug_wire_pin_active_q,
    output var  logic        debug_map_q,
    output var  logic        firmware_enable_bit,
    output var  logic [7:0]  fw_opcode_q,
    output var  logic        fw_cmd_q
);

    // Opcode classes
    function automatic logic op_is_access(input logic [7:0] op);
        case (op)
            swdbg_pkg::OP_DBG_RD_B, swdbg_pkg::OP_DBG_RD_W,
            swdbg_pkg::OP_RD_B,     swdbg_pkg::OP_RD_W,
            swdbg_pkg::OP_DBG_WR_B, swdbg_pkg::OP_DBG_WR_W,
            swdbg_pkg::OP_WR_B,     swdbg_pkg::OP_WR_W: op_is_access = 1'b1;
            default:                                    op_is_access = 1'b0;
        endcase
    endfunction : op_is_access

    function automatic logic op_is_write(input logic [7:0] op);
        op_is_write = ~op[5];
    endfunction : op_is_write

    function automatic logic op_is_word(input logic [7:0] op);
        op_is_word = op[3];
    endfunction : op_is_word

    function automatic logic op_in_dbg_map(input logic [7:0] op);
        op_in_dbg_map = op[2];
    endfunction : op_in_dbg_map

    swdbg_pkg::swdbg_state_t state_q;

    logic        pin_out;
    logic        pin_oe;
    logic        rx_valid;
    logic        rx_bit;
    logic        timeout;
    logic [7:0]  opcode_q;
    logic [15:0] shift_q;
    logic [3:0]  bitcnt_q;
    logic [7:0]  steal_q;
    logic        stole_q;
    logic        bg_pend_q;
    logic [2:0]  ign_q;
    logic        init_q;
    logic [15:0] shift_in;
    logic        bit_last;
    logic        status_hit;
    logic        act_ok;
    logic        act_bad;
    logic [7:0]  status_rd;

    swdbg_bitio u_bitio (
        .mclk     (mclk),
        .rst      (rst),
        .pin_in   (debug_wire_pin_in),
        .tx_en    (state_q == swdbg_pkg::ST_RDATA),
        .tx_bit   (shift_q[15]),
        .pin_out  (pin_out),
        .pin_oe   (pin_oe),
        .rx_valid (rx_valid),
        .rx_bit   (rx_bit),
        .timeout  (timeout)
    );

    assign shift_in = {shift_q[14:0], rx_bit};
    assign bit_last = (state_q == swdbg_pkg::ST_OPCODE) ?
                      (bitcnt_q == swdbg_pkg::BITS_OP) :
                      (bitcnt_q == swdbg_pkg::BITS_WORD);
    assign status_hit = acc_debug_map_q &&
                        (acc_addr_q == swdbg_pkg::STATUS_ADDR);
    assign status_rd = {firmware_enable_bit, debug_wire_pin_active_q, 6'h00};

    // Activation sources; bad ones only stall the CPU briefly
    assign act_ok  = firmware_enable_bit &&
                     ((bg_pend_q && instr_boundary) || tag_hit ||
                      halt_to_debug_instruction);
    assign act_bad = !firmware_enable_bit && !debug_wire_pin_active_q &&
                     (halt_to_debug_instruction || tag_hit);

    // Pin driver outputs registered again to keep one timing point
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            debug_wire_pin_out <= 1'b1;
            debug_wire_pin_oe  <= 1'b0;
        end else begin
            debug_wire_pin_out <= pin_out;
            debug_wire_pin_oe  <= pin_oe;
        end
    end

    // Serial command sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q  <= swdbg_pkg::ST_OPCODE;
            opcode_q <= 8'h00;
            shift_q  <= 16'h0000;
            bitcnt_q <= 4'h0;
        end else if (timeout) begin
            state_q  <= swdbg_pkg::ST_OPCODE;
            opcode_q <= 8'h00;
            bitcnt_q <= 4'h0;
        end else begin
            case (state_q)
                swdbg_pkg::ST_OPCODE,
                swdbg_pkg::ST_ADDR,
                swdbg_pkg::ST_WDATA: begin
                    if (rx_valid) begin
                        shift_q  <= shift_in;
                        bitcnt_q <= bit_last ? 4'h0 : bitcnt_q + 4'h1;
                    end
                    if (rx_valid && bit_last) begin
                        if (state_q == swdbg_pkg::ST_OPCODE) begin
                            opcode_q <= shift_in[7:0];
                            state_q  <= op_is_access(shift_in[7:0]) ?
                                        swdbg_pkg::ST_ADDR :
                                        swdbg_pkg::ST_OPCODE;
                        end else if (state_q == swdbg_pkg::ST_ADDR) begin
                            state_q <= op_is_write(opcode_q) ?
                                       swdbg_pkg::ST_WDATA :
                                       swdbg_pkg::ST_WAIT;
                        end else begin
                            state_q <= swdbg_pkg::ST_WAIT;
                        end
                    end
                end
                swdbg_pkg::ST_WAIT: begin
                    if (status_hit || bus_idle || stole_q) begin
                        state_q <= status_hit ? swdbg_pkg::ST_RDATA :
                                   swdbg_pkg::ST_ACCESS;
                    end
                    if (status_hit) begin
                        shift_q <= {8'h00, status_rd};
                        if (op_is_write(opcode_q)) begin
                            state_q <= swdbg_pkg::ST_OPCODE;
                        end
                    end
                end
                swdbg_pkg::ST_ACCESS: begin
                    if (acc_done) begin
                        shift_q <= acc_rdata;
                        state_q <= op_is_write(opcode_q) ?
                                   swdbg_pkg::ST_OPCODE :
                                   swdbg_pkg::ST_RDATA;
                    end
                end
                swdbg_pkg::ST_RDATA: begin
                    if (rx_valid) begin
                        shift_q  <= {shift_q[14:0], 1'b0};
                        bitcnt_q <= bit_last ? 4'h0 : bitcnt_q + 4'h1;
                        if (bit_last) begin
                            state_q <= swdbg_pkg::ST_OPCODE;
                        end
                    end
                end
                default: begin
                    state_q <= swdbg_pkg::ST_OPCODE;
                end
            endcase
        end
    end

    // Bus master side: address, lanes and data are latched once per access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_addr_q      <= 16'h0000;
            acc_wdata_q     <= 16'h0000;
            acc_write_q     <= 1'b0;
            acc_lane_q      <= 2'b00;
            acc_debug_map_q <= 1'b0;
        end else if (rx_valid && bit_last) begin
            if (state_q == swdbg_pkg::ST_ADDR) begin
                acc_addr_q      <= shift_in;
                acc_write_q     <= op_is_write(opcode_q);
                acc_debug_map_q <= op_in_dbg_map(opcode_q);
                if (op_is_word(opcode_q)) begin
                    acc_lane_q <= 2'b11;
                end else begin
                    acc_lane_q <= shift_in[0] ? 2'b01 : 2'b10;
                end
            end else if (state_q == swdbg_pkg::ST_WDATA) begin
                acc_wdata_q <= shift_in;
            end
        end
    end

    // Idle-cycle search, steal after the limit, freeze for long accesses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc_req_q    <= 1'b0;
            steal_q      <= 8'h00;
            stole_q      <= 1'b0;
            cpu_freeze_q <= 1'b0;
        end else if (state_q == swdbg_pkg::ST_WAIT && !status_hit) begin
            if (bus_idle || stole_q) begin
                acc_req_q <= 1'b1;
            end else if (steal_q == swdbg_pkg::STEAL_LAST) begin
                stole_q      <= 1'b1;
                cpu_freeze_q <= 1'b1;
            end else begin
                steal_q <= steal_q + 8'h01;
            end
        end else if (state_q == swdbg_pkg::ST_ACCESS && !acc_done) begin
            // No answer in the granted cycle: hold the CPU until it comes
            acc_req_q    <= 1'b1;
            cpu_freeze_q <= 1'b1;
        end else begin
            acc_req_q    <= 1'b0;
            steal_q      <= 8'h00;
            stole_q      <= 1'b0;
            cpu_freeze_q <= 1'b0;
        end
    end

    // Enable bit: set after reset in special single-chip mode, else written by a debug-map write of status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            firmware_enable_bit <= swdbg_pkg::STATUS_RST[swdbg_pkg::ENA_BIT];
            init_q              <= 1'b0;
        end else begin
            init_q <= 1'b1;
            if (!init_q && special_single_chip) begin
                firmware_enable_bit <= 1'b1;
            end else if (state_q == swdbg_pkg::ST_WAIT && status_hit &&
                         acc_write_q && acc_lane_q[0]) begin
                firmware_enable_bit <= acc_wdata_q[swdbg_pkg::ENA_BIT];
            end
        end
    end

    // Background state and pending host request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            debug_wire_pin_active_q <= swdbg_pkg::STATUS_RST[swdbg_pkg::ACT_BIT];
            debug_map_q   <= 1'b0;
            bg_pend_q     <= 1'b0;
        end else begin
            if (state_q == swdbg_pkg::ST_OPCODE && rx_valid && bit_last &&
                shift_in[7:0] == swdbg_pkg::OP_BACKGROUND &&
                firmware_enable_bit) begin
                bg_pend_q <= 1'b1;
            end else if (act_ok || firmware_exit) begin
                bg_pend_q <= 1'b0;
            end
            if (!init_q && special_single_chip) begin
                debug_wire_pin_active_q <= 1'b1;
                debug_map_q   <= 1'b1;
            end else if (act_ok) begin
                debug_wire_pin_active_q <= 1'b1;
                debug_map_q   <= 1'b1;
            end else if (firmware_exit) begin
                debug_wire_pin_active_q <= 1'b0;
                debug_map_q   <= 1'b0;
            end
        end
    end

    // Refused activation holds the CPU a few cycles, then it carries on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ign_q       <= 3'h0;
            cpu_stall_q <= 1'b0;
        end else if (act_bad) begin
            ign_q       <= 3'h0;
            cpu_stall_q <= 1'b1;
        end else if (cpu_stall_q) begin
            ign_q <= ign_q + 3'h1;
            if (ign_q == swdbg_pkg::IGN_LAST) begin
                cpu_stall_q <= 1'b0;
            end
        end
    end

    // Other opcodes go to the resident firmware, only while active
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fw_opcode_q <= 8'h00;
            fw_cmd_q    <= 1'b0;
        end else begin
            fw_cmd_q <= 1'b0;
            if (state_q == swdbg_pkg::ST_OPCODE && rx_valid && bit_last &&
                !op_is_access(shift_in[7:0]) &&
                shift_in[7:0] != swdbg_pkg::OP_BACKGROUND &&
                debug_wire_pin_active_q && !timeout) begin
                fw_opcode_q <= shift_in[7:0];
                fw_cmd_q    <= 1'b1;
            end
        end
    end

endmodule : swdbg_core

`default_nettype wire

// >>> test/swdbg_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module swdbg_core_monitor (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        debug_wire_pin_out,
    input wire logic        debug_wire_pin_oe,
    input wire logic        bus_idle,
    input wire logic        acc_done,
    input wire logic        acc_req_q,
    input wire logic [15:0] acc_addr_q,
    input wire logic        cpu_freeze_q,
    input wire logic        cpu_stall_q,
    input wire logic        debug_wire_pin_active_q,
    input wire logic        debug_map_q,
    input wire logic        firmware_enable_bit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic       low;
    logic       low_q;
    logic [5:0] lcnt_q;
    assign low = debug_wire_pin_oe && !debug_wire_pin_out;
    // Length of the device's own low drive, to time a zero bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_q  <= 1'b0;
            lcnt_q <= 6'h00;
        end else begin
            low_q  <= low;
            lcnt_q <= low ? lcnt_q + 6'h01 : 6'h00;
        end
    end
    sequence zero_tail;
        debug_wire_pin_oe && debug_wire_pin_out ##1 !debug_wire_pin_oe;
    endsequence
    zero_width_a: assert property (
        low_q && !low |-> lcnt_q == 6'h0D ##0 zero_tail)
        else $error("zero bit drive wrong");
    one_pulse_a: assert property (
        $rose(debug_wire_pin_oe) && debug_wire_pin_out |=> !debug_wire_pin_oe)
        else $error("one bit pulse too long");
    stall_len_a: assert property (
        $rose(cpu_stall_q) |-> cpu_stall_q [*4] ##1 !cpu_stall_q)
        else $error("stall length wrong");
    stall_cause_a: assert property (
        $rose(cpu_stall_q) |-> !firmware_enable_bit && !debug_wire_pin_active_q)
        else $error("stall while enabled");
    active_en_a: assert property (
        $rose(debug_wire_pin_active_q) |-> firmware_enable_bit)
        else $error("active without enable");
    map_follow_a: assert property (debug_map_q == debug_wire_pin_active_q)
        else $error("map differs from active");
    req_hold_a: assert property (
        acc_req_q && !acc_done |=> acc_req_q && $stable(acc_addr_q))
        else $error("request dropped early");
    steal_freeze_a: assert property (
        $rose(acc_req_q) && !$past(bus_idle) |-> ##[0:1] cpu_freeze_q)
        else $error("stolen cycle without freeze");
    freeze_hold_a: assert property (
        cpu_freeze_q && acc_req_q && !acc_done |=> cpu_freeze_q)
        else $error("freeze released early");
endmodule : swdbg_core_monitor

`default_nettype wire

// >>> test/swdbg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module swdbg_host_model (
    input  wire logic mclk,
    input  wire logic pin,
    output var  logic host_low
);
    initial host_low = 1'b0;
    // Bits last 20 cycles so a device zero has ended before the next start
    task automatic put(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            host_low = 1'b1;
            repeat (v[i] ? 3 : 14) @(posedge mclk);
            #1 host_low = 1'b0;
            repeat (v[i] ? 17 : 6) @(posedge mclk);
            #1;
        end
    endtask : put
    task automatic get(output logic [15:0] v);
        for (int i = 15; i >= 0; i--) begin
            host_low = 1'b1;
            // Held until the device's own low drive has taken over
            repeat (5) @(posedge mclk);
            #1 host_low = 1'b0;
            repeat (5) @(posedge mclk);
            #1 v[i] = pin;
            repeat (10) @(posedge mclk);
            #1;
        end
    endtask : get
    task automatic rd(input logic [7:0] op, input logic [15:0] a,
                      output logic [15:0] v);
        put({8'h00, op}, 8);
        put(a, 16);
        repeat (150) @(posedge mclk);
        #1 get(v);
        repeat (150) @(posedge mclk);
        #1;
    endtask : rd
    task automatic wr(input logic [7:0] op, input logic [15:0] a,
                      input logic [15:0] dat);
        put({8'h00, op}, 8);
        put(a, 16);
        put(dat, 16);
        repeat (150) @(posedge mclk);
        #1;
    endtask : wr
endmodule : swdbg_host_model

`default_nettype wire

// >>> test/swdbg_core_test.sv
`timescale 1ns/1ps
`default_nettype none

module swdbg_core_test;
    logic mclk, rst, pin, host_low, special_single_chip, instr_boundary;
    logic tag_hit, halt_to_debug_instruction, firmware_exit, bus_idle;
    logic acc_done, acc_req_q, acc_write_q, acc_debug_map_q, cpu_freeze_q;
    logic cpu_stall_q, debug_wire_pin_active_q, debug_map_q, firmware_enable_bit;
    logic debug_wire_pin_out, debug_wire_pin_oe, froze;
    logic [1:0]  acc_lane_q;
    logic [3:0]  seen_ctl;
    logic [15:0] acc_rdata, acc_addr_q, acc_wdata_q, seen_addr, seen_wd, d;
    int          err_count, n_compared, bw;
    int          lat = 1;
    logic        fw_cmd;
    logic [7:0]  fw_op, seen_fw;
    logic [15:0] ta [4] = '{16'h1235, 16'h2000, 16'h1234, 16'h3000};
    logic [7:0]  to [4] = '{8'hE0, 8'hE4, 8'hE8, 8'hC4};
    logic [3:0]  tc [4] = '{4'h2, 4'h5, 4'h6, 4'hD};

    swdbg_core u_swdbg_core (.debug_wire_pin_in(pin), .fw_opcode_q(fw_op),
                             .fw_cmd_q(fw_cmd), .*);
    swdbg_host_model u_host (.mclk(mclk), .pin(pin), .host_low(host_low));
    // Pulled high when nobody drives
    assign pin = debug_wire_pin_oe ? debug_wire_pin_out : !host_low;

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Answers a granted access after lat cycles; above one it must freeze
    always @(posedge mclk) begin
        #1;
        if (fw_cmd) seen_fw = fw_op;
        if (acc_req_q) begin
            seen_addr = acc_addr_q;
            seen_wd   = acc_wdata_q;
            seen_ctl  = {acc_write_q, acc_lane_q, acc_debug_map_q};
        end
        froze = froze | cpu_freeze_q;
        bw = (acc_req_q && !acc_done) ? bw + 1 : 0;
        acc_done = (bw == lat);
    end
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic step(ref logic s);
        s = 1'b1;
        for (int k = 0; k < 40 && s !== 1'b1; k++) ;
        @(posedge mclk);
        #1 s = 1'b0;
        @(posedge mclk);
        #1;
    endtask : step
    task automatic do_reset(input logic s);
        rst = 1'b1;
        special_single_chip = s;
        repeat (4) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask : do_reset
    task automatic end_sim;
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    initial begin
        {instr_boundary, tag_hit, halt_to_debug_instruction} = 3'h0;
        {firmware_exit, acc_done, froze, bus_idle} = 4'h1;
        acc_rdata = 16'hBEEF;
        do_reset(1'b0);
        u_host.rd(8'hE4, 16'hFF01, d);
        check(d, 16'h0000);
        u_host.put(16'h0090, 8);
        repeat (12) @(posedge mclk);
        #1 check({cpu_stall_q, debug_wire_pin_active_q}, 2'h0);
        step(halt_to_debug_instruction);
        check({cpu_stall_q, debug_wire_pin_active_q}, 2'h2);
        repeat (150) @(posedge mclk);
        #1 u_host.wr(8'hC4, 16'hFF01, 16'h0080);
        u_host.rd(8'hE4, 16'hFF01, d);
        check(d, 16'h0080);
        u_host.put(16'h0090, 8);
        repeat (20) @(posedge mclk);
        #1 check(debug_wire_pin_active_q, 1'b0);
        step(instr_boundary);
        check({debug_wire_pin_active_q, debug_map_q}, 2'h3);
        u_host.rd(8'hE4, 16'hFF01, d);
        check(d, 16'h00C0);
        step(firmware_exit);
        check(debug_wire_pin_active_q, 1'b0);
        step(tag_hit);
        check(debug_wire_pin_active_q, 1'b1);
        u_host.put(16'h0062, 8);
        check(seen_fw, 8'h62);
        step(firmware_exit);
        for (int i = 0; i < 4; i++) begin
            bus_idle = (i != 3);
            froze = 1'b0;
            if (to[i][5]) u_host.rd(to[i], ta[i], d);
            else u_host.wr(to[i], ta[i], 16'h5A00);
            check(seen_addr, ta[i]);
            check({froze, seen_ctl}, {(i == 3), tc[i]});
        end
        check(seen_wd, 16'h5A00);
        check(d, 16'hBEEF);
        bus_idle = 1'b1;
        lat = 3;
        froze = 1'b0;
        u_host.rd(8'hE8, 16'h4000, d);
        check(froze, 1'b1);
        lat = 1;
        u_host.put(16'h000F, 4);
        repeat (600) @(posedge mclk);
        #1 u_host.rd(8'hE4, 16'hFF01, d);
        check(d, 16'h0080);
        do_reset(1'b1);
        check({firmware_enable_bit, debug_wire_pin_active_q}, 2'h3);
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        end_sim;
    end
endmodule : swdbg_core_test

bind swdbg_core swdbg_core_monitor u_swdbg_core_monitor (.*);

`default_nettype wire
